// *** hw/acs_adc_conversion_sequencer.sv ***
`timescale 1ns/100ps
// Summary of operation
// R1: Three-bit channel field picks one of eight analog inputs, value n picks input n.
// R2: Standard conversion gives 8 result bits, precision conversion gives 10.
// R3: Pseudo-idle select plus start halts the processor, peripherals keep running.
// R4: Software must enable the end-of-conversion interrupt when using precision mode.
// R5: Other interrupts stay pending until the precision conversion is over.
// R6: Per-pin config bits choose which shared pins serve as analog inputs.
// R7: A start on a channel not enabled in the config bits does nothing; the code sets the refused status bit for such a start.
// R8: A conversion lasts 11 converter clocks: one sample, ten bit steps.
// R9: Software waits 4 us after enabling before the first conversion.
// R10: Writing one to control bit 3 launches one conversion.
// R11: Hardware clears the start bit when the conversion completes.
// R12: End flag, control bit 4, sets with the result; only software clears it.
// R13: With the converter interrupt enabled, flag setting requests an interrupt.
// R14: Result is 3ffh at reference, 000h at ground, linear between; at prescale 1 the code decides each bit from the previous trial's compare.
// R15: Converter clock divides peripheral clock by 64 for zero, else twice value.
// R16: Clearing converter enable puts the converter in standby.
// R17: Start while busy is ignored; channel is taken at conversion start; the code sets the refused status bit for a busy start.
// R18: Taking the end interrupt ends pseudo-idle and resumes the processor.
module acs_adc_conversion_sequencer (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic compare_high_pin,
    output logic [9:0] trial_code,
    output logic sample_hold,
    output logic [2:0] mux_select,
    output logic [7:0] analog_pin_enable,
    output logic converter_powered,
    output logic cpu_halt,
    output logic other_irq_hold,
    input wire logic irq_ack,
    output logic irq
);
    // ****************************************
    // Register state
    // ****************************************
    logic pseudo_idle_select;
    logic converter_enable;
    logic end_of_conversion_flag;
    logic [acs_pkg::CH_W-1:0] channel_select;
    logic [7:0] channel_config_bits;
    logic [acs_pkg::PRESC_W-1:0] clock_prescale_value;
    logic [7:0] result_high_byte;
    logic [1:0] result_low_byte;
    logic [acs_pkg::IRQ_W-1:0] irq_stat;
    logic [acs_pkg::IRQ_W-1:0] conversion_irq_enable;

    acs_pkg::acs_state_t state;
    logic [acs_pkg::DIV_W-1:0] div_cnt;
    logic [3:0] bit_idx;
    logic [acs_pkg::RES_W-1:0] sar;
    logic precision;
    logic cmp_meta;
    logic cmp_sync;

    // ****************************************
    // APB decode
    // ****************************************
    wire apb_setup = psel & ~penable & ce;
    wire apb_access = psel & penable & ce;
    wire hit_ctrl = paddr == acs_pkg::OFS_CTRL;
    wire hit_chcfg = paddr == acs_pkg::OFS_CHCFG;
    wire hit_presc = paddr == acs_pkg::OFS_PRESC;
    wire hit_hi = paddr == acs_pkg::OFS_RES_HI;
    wire hit_lo = paddr == acs_pkg::OFS_RES_LO;
    wire hit_stat = paddr == acs_pkg::OFS_IRQ_STAT;
    wire hit_ien = paddr == acs_pkg::OFS_IRQ_EN;
    wire hit_any = hit_ctrl | hit_chcfg | hit_presc | hit_hi | hit_lo | hit_stat | hit_ien;
    wire wr = apb_access & pwrite & hit_any;
    wire wr_ctrl = wr & hit_ctrl;
    wire busy = state != acs_pkg::ST_IDLE;

    assign pready = apb_access;
    assign pslverr = apb_access & ~hit_any;

    wire [7:0] ctrl_rd = {1'b0, pseudo_idle_select, converter_enable,
                          end_of_conversion_flag, busy, channel_select};
    wire [7:0] rd_mux = hit_ctrl ? ctrl_rd :
                        hit_chcfg ? channel_config_bits :
                        hit_presc ? {3'h0, clock_prescale_value} :
                        hit_hi ? result_high_byte :
                        hit_lo ? {6'h00, result_low_byte} :
                        hit_stat ? {6'h00, irq_stat} :
                        hit_ien ? {6'h00, conversion_irq_enable} : 8'h00;

    // ****************************************
    // Start qualification
    // ****************************************
    wire [acs_pkg::CH_W-1:0] wr_ch = pwdata[acs_pkg::CTRL_CH_LSB +: acs_pkg::CH_W];
    wire wr_start = wr_ctrl & pwdata[acs_pkg::CTRL_START];
    wire wr_en = pwdata[acs_pkg::CTRL_EN];
    // R7: enabled channel only
    wire ch_ok = channel_config_bits[wr_ch];
    // R10: launch on start write
    // R17: ignored while busy
    wire start_ok = wr_start & ~busy & ch_ok & wr_en;
    wire start_refused = wr_start & ~start_ok;

    // ****************************************
    // Converter clock
    // ****************************************
    // R15: zero selects divide by 64
    wire [acs_pkg::DIV_W-1:0] div_val = (clock_prescale_value == '0) ? acs_pkg::DIV_ZERO :
                                        {1'b0, clock_prescale_value, 1'b0};
    wire tick = busy & (div_cnt == div_val - 7'h01);
    wire done = (state == acs_pkg::ST_CONV) & tick & (bit_idx == 4'h0);
    wire [acs_pkg::RES_W-1:0] bit_mask = acs_pkg::RES_W'(1) << bit_idx;
    wire [acs_pkg::RES_W-1:0] sar_kept = cmp_sync ? sar : (sar & ~bit_mask);
    wire [acs_pkg::RES_W-1:0] sar_next_trial = sar_kept | (bit_mask >> 1);
    // R2: standard mode drops the two low bits
    wire [acs_pkg::RES_W-1:0] res_final = precision ? sar_kept :
        {sar_kept[acs_pkg::RES_W-1:acs_pkg::STD_DROP], 2'b00};
    wire eoc_set = done;
    wire eoc_clr = wr_ctrl & ~pwdata[acs_pkg::CTRL_EOC];

    assign trial_code = sar;
    assign sample_hold = state == acs_pkg::ST_SAMPLE;
    // R6: pins follow config bits
    assign analog_pin_enable = channel_config_bits;
    // R16: standby when disabled
    assign converter_powered = converter_enable;
    // R5: other interrupts held
    assign other_irq_hold = cpu_halt & busy;
    // R13: unmasked status drives irq
    assign irq = |(irq_stat & conversion_irq_enable);

    // ****************************************
    // Comparator synchroniser
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else if (ce) begin
            cmp_meta <= compare_high_pin;
            cmp_sync <= cmp_meta;
        end
    end

    // ****************************************
    // Register file
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= '0;
            pseudo_idle_select <= 1'b0;
            converter_enable <= 1'b0;
            channel_select <= '0;
            channel_config_bits <= acs_pkg::RST_BYTE;
            clock_prescale_value <= '0;
            conversion_irq_enable <= '0;
        end else if (ce) begin
            // Read data is taken at setup, so it shows the state one cycle early
            if (apb_setup) begin
                prdata <= {24'h000000, rd_mux};
            end
            if (wr_ctrl) begin
                pseudo_idle_select <= pwdata[acs_pkg::CTRL_IDLE_SEL];
                converter_enable <= wr_en;
                channel_select <= wr_ch;
            end
            if (wr & hit_chcfg) begin
                channel_config_bits <= pwdata[7:0];
            end
            if (wr & hit_presc) begin
                clock_prescale_value <= pwdata[acs_pkg::PRESC_W-1:0];
            end
            if (wr & hit_ien) begin
                conversion_irq_enable <= pwdata[acs_pkg::IRQ_W-1:0];
            end
        end
    end

    // ****************************************
    // Flags and interrupt status
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            end_of_conversion_flag <= 1'b0;
            irq_stat <= '0;
        end else if (ce) begin
            // R12: set wins over software clear
            if (eoc_set) begin
                end_of_conversion_flag <= 1'b1;
            end else if (eoc_clr) begin
                end_of_conversion_flag <= 1'b0;
            end
            irq_stat <= (irq_stat & ~({acs_pkg::IRQ_W{wr & hit_stat}} &
                         pwdata[acs_pkg::IRQ_W-1:0])) | {eoc_set, start_refused};
        end
    end

    // ****************************************
    // Processor halt
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cpu_halt <= 1'b0;
        end else if (ce) begin
            // R3: halt on precision start
            if (start_ok & pwdata[acs_pkg::CTRL_IDLE_SEL]) begin
                cpu_halt <= 1'b1;
            // R18: interrupt taken resumes
            end else if (irq_ack | (busy & ~converter_enable)) begin
                cpu_halt <= 1'b0;
            end
        end
    end

    // ****************************************
    // Conversion sequencer
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= acs_pkg::ST_IDLE;
            div_cnt <= '0;
            bit_idx <= '0;
            sar <= '0;
            precision <= 1'b0;
            mux_select <= '0;
            result_high_byte <= acs_pkg::RST_BYTE;
            result_low_byte <= 2'b00;
        end else if (ce) begin
            div_cnt <= (tick | ~busy) ? '0 : div_cnt + 7'h01;
            unique case (state)
                acs_pkg::ST_IDLE: begin
                    if (start_ok) begin
                        // R1: channel routed to mux
                        // R17: channel latched at start
                        mux_select <= wr_ch;
                        precision <= pwdata[acs_pkg::CTRL_IDLE_SEL];
                        sar <= '0;
                        state <= acs_pkg::ST_SAMPLE;
                    end
                end
                acs_pkg::ST_SAMPLE: begin
                    // R8: one sample period then ten steps
                    if (tick) begin
                        bit_idx <= acs_pkg::BIT_STEPS - 4'h1;
                        sar <= acs_pkg::RES_W'(1) << (acs_pkg::RES_W - 1);
                        state <= acs_pkg::ST_CONV;
                    end
                end
                acs_pkg::ST_CONV: begin
                    // R14: successive approximation saturates at both ends
                    if (tick) begin
                        sar <= sar_next_trial;
                        bit_idx <= bit_idx - 4'h1;
                        if (bit_idx == 4'h0) begin
                            result_high_byte <= res_final[acs_pkg::RES_W-1:acs_pkg::STD_DROP];
                            result_low_byte <= res_final[acs_pkg::STD_DROP-1:0];
                            // R11: start bit reads busy, clears here
                            state <= acs_pkg::ST_IDLE;
                        end
                    end
                end
                default: state <= acs_pkg::ST_IDLE;
            endcase
            // R16: standby aborts a conversion
            if (~converter_enable & busy) begin
                state <= acs_pkg::ST_IDLE;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    logic [3:0] tick_cnt;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_cnt <= '0;
        end else if (ce) begin
            tick_cnt <= start_ok ? '0 : tick_cnt + {3'h0, tick};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst || !ce);

    property p_busy_ignore;
        busy && wr_start |=> state != acs_pkg::ST_SAMPLE || $past(state) == acs_pkg::ST_SAMPLE;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("start taken while busy"); // R17
    property p_chan_off;
        !busy && wr_start && !ch_ok |=> state == acs_pkg::ST_IDLE && !cpu_halt;
    endproperty
    a_chan_off: assert property (p_chan_off) else $error("start on disabled channel"); // R7
    property p_eleven;
        done |-> tick_cnt == acs_pkg::CONV_TICKS - 4'h1;
    endproperty
    a_eleven: assert property (p_eleven) else $error("conversion length wrong"); // R8
    property p_done_flags;
        done |=> !busy && end_of_conversion_flag && ctrl_rd[acs_pkg::CTRL_START] == 1'b0;
    endproperty
    a_done_flags: assert property (p_done_flags) else $error("completion flags wrong"); // R11
    property p_set_wins;
        eoc_set && eoc_clr |=> end_of_conversion_flag;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("end flag lost"); // R12
    property p_irq;
        eoc_set && conversion_irq_enable[acs_pkg::IRQ_EOC] |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("no interrupt on end flag"); // R13
    property p_halt;
        start_ok && pwdata[acs_pkg::CTRL_IDLE_SEL] |=> cpu_halt && other_irq_hold;
    endproperty
    a_halt: assert property (p_halt) else $error("no halt in precision mode"); // R3
    property p_resume;
        irq_ack && !start_ok |=> !cpu_halt;
    endproperty
    a_resume: assert property (p_resume) else $error("halt kept after ack"); // R18
    property p_div_one;
        tick && clock_prescale_value == 5'h01 && state == acs_pkg::ST_CONV
            && bit_idx != 4'h0 && converter_enable |=> !tick ##1 tick;
    endproperty
    a_div_one: assert property (p_div_one) else $error("divide by two wrong"); // R15
    property p_mux;
        start_ok |=> mux_select == $past(wr_ch) && state == acs_pkg::ST_SAMPLE;
    endproperty
    a_mux: assert property (p_mux) else $error("channel not latched"); // R1
    property p_std;
        done && !precision |=> result_low_byte == 2'b00;
    endproperty
    a_std: assert property (p_std) else $error("standard result has low bits"); // R2
    property p_standby;
        busy && !converter_enable |=> state == acs_pkg::ST_IDLE;
    endproperty
    a_standby: assert property (p_standby) else $error("runs in standby"); // R16
endmodule : acs_adc_conversion_sequencer

// *** hw/acs_pkg.sv ***
package acs_pkg;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CHCFG = 8'h04;
    localparam logic [7:0] OFS_PRESC = 8'h08;
    localparam logic [7:0] OFS_RES_HI = 8'h0c;
    localparam logic [7:0] OFS_RES_LO = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN = 8'h18;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int CTRL_IDLE_SEL = 6;
    localparam int CTRL_EN = 5;
    localparam int CTRL_EOC = 4;
    localparam int CTRL_START = 3;
    localparam int CTRL_CH_LSB = 0;
    localparam int CH_W = 3;
    localparam int PRESC_W = 5;

    // ****************************************
    // Interrupt bits, same layout in status and enable
    // ****************************************
    localparam int IRQ_REFUSED = 0;
    localparam int IRQ_EOC = 1;
    localparam int IRQ_W = 2;

    // ****************************************
    // Conversion timing
    // ****************************************
    localparam int RES_W = 10;
    localparam int STD_DROP = 2;
    localparam int DIV_W = 7;
    localparam logic [DIV_W-1:0] DIV_ZERO = 7'h40;
    localparam logic [3:0] BIT_STEPS = 4'ha;
    localparam logic [3:0] CONV_TICKS = 4'hb;

    localparam logic [7:0] RST_BYTE = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONV = 2'b10
    } acs_state_t;
endpackage : acs_pkg

// *** tb/acs_analog_model.sv ***
`timescale 1ns/100ps
module acs_analog_model (
    input wire logic clk,
    input wire logic [2:0] mux_select,
    input wire logic [9:0] trial_code,
    input wire logic sample_hold,
    input wire logic converter_powered,
    output logic compare_high_pin
);
    // Levels in code units; 3ff and 000 stand for reference and ground
    localparam logic [9:0] LEVEL [8] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa, 10'h001, 10'h3fe,
        10'h200, 10'h1ff};
    logic [9:0] held = 10'h000;
    logic flip = 1'b0;
    always @(posedge clk) begin
        if (sample_hold) held <= LEVEL[mux_select];
        flip <= ~flip;
    end
    // linear comparison
    // Unpowered core gives a changing level, never a steady last value
    assign compare_high_pin = converter_powered ? (held >= trial_code) : flip;
endmodule : acs_analog_model

// *** tb/testbench.sv ***
`timescale 1ns/100ps
module testbench;
    localparam logic [9:0] LEVEL [8] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa, 10'h001, 10'h3fe,
        10'h200, 10'h1ff};
    localparam logic [7:0] PRESC_SET [3] = '{8'h00, 8'h01, 8'h1f};
    localparam int PERIOD [3] = '{64, 2, 62};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic irq_ack = 1'b0;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, perr, compare_high_pin, sample_hold, converter_powered;
    logic cpu_halt, other_irq_hold, irq;
    logic [9:0] trial_code;
    logic [2:0] mux_select;
    logic [7:0] analog_pin_enable;
    int miscompares = 0;
    int samples_checked = 0;
    int n_hold, n_total;
    always #2.5 clk = ~clk;
    acs_adc_conversion_sequencer acs_adc_conversion_sequencer_inst (.clk(clk),
        .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .compare_high_pin(compare_high_pin), .trial_code(trial_code),
        .sample_hold(sample_hold), .mux_select(mux_select),
        .analog_pin_enable(analog_pin_enable), .converter_powered(converter_powered),
        .cpu_halt(cpu_halt), .other_irq_hold(other_irq_hold), .irq_ack(irq_ack), .irq(irq));
    acs_analog_model acs_analog_model_inst (.clk(clk), .mux_select(mux_select),
        .trial_code(trial_code), .sample_hold(sample_hold),
        .converter_powered(converter_powered), .compare_high_pin(compare_high_pin));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : chk
    // Idle edge first, so release and next setup never share a time step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rdata = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 40) begin
            miscompares++;
            results();
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, {24'h0, exp}, rdata);
    endtask : rdc
    task automatic wait_idle;
        int k;
        for (k = 0; k < 300; k++) begin
            apb(1'b0, acs_pkg::OFS_CTRL, 32'h0);
            if (rdata[acs_pkg::CTRL_START] === 1'b0) break;
        end
        if (k >= 300) begin
            miscompares++;
            results();
        end
    endtask : wait_idle
    task automatic measure(input int period);
        n_hold = 0;
        n_total = 0;
        while (irq !== 1'b1 && n_total < 1000) begin
            @(negedge clk);
            if (sample_hold === 1'b1) n_hold++;
            if (irq !== 1'b1) n_total++;
        end
        chk("sample period", 32'(period), 32'(n_hold));
        chk("conversion time", 32'(11 * period), 32'(n_total));
        if (n_total >= 1000) results();
    endtask : measure
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        int i, ch, m;
        logic [7:0] ctl;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 7; i++) rdc("reset value", 8'(i * 4), 8'h00);
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, perr});
        chk("unmapped data", 32'h0, rdata);
        wr(acs_pkg::OFS_CHCFG, 8'hff);
        wr(acs_pkg::OFS_PRESC, 8'h02);
        wr(acs_pkg::OFS_CTRL, 8'h20);
        @(negedge clk);
        chk("pin enable", 32'hff, {24'h0, analog_pin_enable});
        chk("powered", 32'h1, {31'h0, converter_powered});
        repeat (800) @(posedge clk);
        for (m = 0; m < 2; m++) begin
            wr(acs_pkg::OFS_IRQ_EN, m ? 8'h03 : 8'h00);
            for (ch = 0; ch < 8; ch++) begin
                ctl = 8'(ch) | (m ? 8'h68 : 8'h28);
                wr(acs_pkg::OFS_CTRL, ctl);
                @(negedge clk);
                chk("mux select", 32'(ch), {29'h0, mux_select});
                chk("cpu halt", 32'(m), {31'h0, cpu_halt});
                chk("irq hold", 32'(m), {31'h0, other_irq_hold});
                wait_idle();
                rdc("result high", acs_pkg::OFS_RES_HI, LEVEL[ch][9:2]);
                rdc("result low", acs_pkg::OFS_RES_LO, m ? {6'h0, LEVEL[ch][1:0]} : 8'h00);
                rdc("ctrl done", acs_pkg::OFS_CTRL, ctl & 8'hf7 | 8'h10);
                rdc("status", acs_pkg::OFS_IRQ_STAT, 8'h02);
                @(negedge clk);
                chk("irq", 32'(m), {31'h0, irq});
                chk("irq hold after", 32'h0, {31'h0, other_irq_hold});
                chk("halt until ack", 32'(m), {31'h0, cpu_halt});
                @(posedge clk);
                irq_ack <= 1'b1;
                @(posedge clk);
                irq_ack <= 1'b0;
                @(negedge clk);
                chk("halt after ack", 32'h0, {31'h0, cpu_halt});
                wr(acs_pkg::OFS_CTRL, 8'h20);
                wr(acs_pkg::OFS_IRQ_STAT, 8'h03);
                rdc("flag cleared", acs_pkg::OFS_CTRL, 8'h20);
                chk("irq rearmed", 32'h0, {31'h0, irq});
            end
        end
        wr(acs_pkg::OFS_CTRL, 8'h2b);
        wr(acs_pkg::OFS_CTRL, 8'h2d);
        @(negedge clk);
        chk("latched channel", 32'h3, {29'h0, mux_select});
        wait_idle();
        rdc("busy result", acs_pkg::OFS_RES_HI, LEVEL[3][9:2]);
        rdc("busy refused", acs_pkg::OFS_IRQ_STAT, 8'h03);
        wr(acs_pkg::OFS_CTRL, 8'h20);
        wr(acs_pkg::OFS_IRQ_STAT, 8'h03);
        wr(acs_pkg::OFS_CHCFG, 8'hf7);
        wr(acs_pkg::OFS_CTRL, 8'h2b);
        rdc("no start", acs_pkg::OFS_CTRL, 8'h23);
        rdc("cfg refused", acs_pkg::OFS_IRQ_STAT, 8'h01);
        chk("pin subset", 32'hf7, {24'h0, analog_pin_enable});
        wr(acs_pkg::OFS_IRQ_STAT, 8'h01);
        wr(acs_pkg::OFS_CHCFG, 8'hff);
        for (i = 0; i < 3; i++) begin
            wr(acs_pkg::OFS_PRESC, PRESC_SET[i]);
            wr(acs_pkg::OFS_CTRL, 8'h28);
            measure(PERIOD[i]);
            wr(acs_pkg::OFS_CTRL, 8'h20);
            wr(acs_pkg::OFS_IRQ_STAT, 8'h03);
        end
        wr(acs_pkg::OFS_PRESC, 8'h02);
        // Clock enable low must freeze a conversion in its sample period
        wr(acs_pkg::OFS_CTRL, 8'h2a);
        @(posedge clk);
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk("frozen sample", 32'h1, {31'h0, sample_hold});
        @(posedge clk);
        ce <= 1'b1;
        wait_idle();
        rdc("frozen result", acs_pkg::OFS_RES_HI, LEVEL[2][9:2]);
        wr(acs_pkg::OFS_CTRL, 8'h20);
        wr(acs_pkg::OFS_IRQ_STAT, 8'h03);
        wr(acs_pkg::OFS_CTRL, 8'h68);
        wr(acs_pkg::OFS_CTRL, 8'h00);
        @(negedge clk);
        chk("standby", 32'h0, {31'h0, converter_powered});
        // Abort clears the halt one cycle after enable drops
        @(negedge clk);
        chk("abort halt", 32'h0, {31'h0, cpu_halt});
        repeat (60) @(posedge clk);
        rdc("abort ctrl", acs_pkg::OFS_CTRL, 8'h00);
        rdc("abort status", acs_pkg::OFS_IRQ_STAT, 8'h00);
        wr(acs_pkg::OFS_CTRL, 8'h08);
        rdc("disabled start", acs_pkg::OFS_CTRL, 8'h00);
        rdc("disabled refused", acs_pkg::OFS_IRQ_STAT, 8'h01);
        results();
    end
endmodule : testbench
